/* File: verilog/crc_calc_pkg.sv */
// Constants, register map and carrier types of the check engine
package crc_calc_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LEN_W  = 4;
  localparam int unsigned CNT_W  = 5;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL0    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_ACC_LO   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ACC_HI   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_POLY_LO  = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_POLY_HI  = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK     = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_SHIFT_LO = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_SHIFT_HI = 4'hb;

  // ==========================================================================
  // Field positions of the first control register, and the done bit of status and mask
  localparam int unsigned CTRL0_ENABLE_BIT = 7;
  localparam int unsigned CTRL0_BUSY_BIT   = 5;
  localparam int unsigned CTRL0_AUG_BIT    = 4;
  localparam int unsigned CTRL0_SRC_BIT    = 2;
  localparam int unsigned CTRL0_ORDER_BIT  = 1;
  localparam int unsigned DONE_BIT         = 0;

  // ==========================================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [LEN_W-1:0]  LEN_RST   = 4'hf;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 5'h01;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic enable;
    logic augment;
    logic src_scan;
    logic order_lsb;
  } ctrl_t;

  typedef struct packed {
    logic [LEN_W-1:0] poly_len;
    logic [LEN_W-1:0] data_len;
  } len_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DATA,
    ST_AUG
  } eng_state_t;

  // ==========================================================================
  // Mask of bits len down to 0
  function automatic logic [WORD_W-1:0] len_mask(input logic [LEN_W-1:0] len);
    logic [WORD_W-1:0] m;
    m = WORD_RST;
    for (int i = 0; i < WORD_W; i++)
    begin
      m[i] = (i <= int'(len));
    end
    return m;
  endfunction : len_mask

  // Count of bits for a length field, one more than the field
  function automatic logic [CNT_W-1:0] len_count(input logic [LEN_W-1:0] len);
    return {1'b0, len} + CNT_ONE;
  endfunction : len_count

endpackage : crc_calc_pkg

/* File: verilog/crc_lfsr_step.sv */
// One bit step of the programmable feedback shift register
`timescale 1ns/1ps
`default_nettype none

module crc_lfsr_step
  import crc_calc_pkg::*;
(
  input  wire logic [crc_calc_pkg::WORD_W-1:0] acc,
  input  wire logic [crc_calc_pkg::WORD_W-1:0] poly,
  input  wire logic [crc_calc_pkg::LEN_W-1:0]  poly_len,
  input  wire logic                            bit_in,
  output logic      [crc_calc_pkg::WORD_W-1:0] acc_next
);

  // ==========================================================================
  // Feedback taken at the top of the programmed length
  logic                feedback;
  logic [WORD_W-1:0]   shifted;

  always_comb
  begin
    feedback = acc[poly_len] ^ bit_in;
    shifted  = {acc[WORD_W-2:0], 1'b0};
    if (feedback)
    begin
      shifted = shifted ^ poly;
    end
    // Bits above the length stay zero so readback is clean
    acc_next = shifted & len_mask(poly_len);
  end

endmodule : crc_lfsr_step

`default_nettype wire

/* File: verilog/crc_done_irq.sv */
// Sticky completion flag, its mask and the level interrupt
`timescale 1ns/1ps
`default_nettype none

module crc_done_irq
  import crc_calc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic done_event,
  input  wire logic flag_clear,
  input  wire logic mask_we,
  input  wire logic mask_wdata,
  output logic      flag_q,
  output logic      mask_q,
  output logic      irq_q
);

  // ==========================================================================
  // Set beats clear so a finish during the status read is kept
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flag_q <= 1'b0;
    else if (done_event)
      flag_q <= 1'b1;
    else if (flag_clear)
      flag_q <= 1'b0;
  end

  // Enable bit of the completion interrupt
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= 1'b0;
    else if (mask_we)
      mask_q <= mask_wdata;
  end

  // Registered level, one cycle behind flag and mask
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_q <= 1'b0;
    else
      irq_q <= flag_q & mask_q;
  end

endmodule : crc_done_irq

`default_nettype wire

/* File: verilog/crc_calc_engine.sv */
// Programmable check engine: registers, staging shifter and accumulator
//
// Behaviour
// - Words come from software data writes or from the memory scanner port.
// - Length field picks 1 to 16 used bits; higher data bits ignored.
// - Each word goes to a staging shifter, then bitwise into the accumulator.
// - Order bit clear: bit at the length position enters first.
// - Order bit set: bit zero enters first, reversed order.
// - With software as the source, a write to the low data byte latches the word and starts it.
// - The finished check value is read back from the accumulator bytes.
// - Augment bit set: polynomial-length zero bits follow the data.
// - Augment bit clear: shifting ends with the last data bit.
// - A fall of busy is the completion event.
// - Every busy fall sets the done flag, enable or not.
// - The done flag stays set until software clears it.
// - Interrupt is raised only when flag and enable are both set.
`timescale 1ns/1ps
`default_nettype none

module crc_calc_engine
  import crc_calc_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic [crc_calc_pkg::ADDR_W-1:0] addr,
  input  wire logic [crc_calc_pkg::DATA_W-1:0] wdata,
  input  wire logic                            wr_en,
  input  wire logic                            rd_en,
  output logic      [crc_calc_pkg::DATA_W-1:0] rdata_q,
  input  wire logic                            scan_valid,
  input  wire logic [crc_calc_pkg::WORD_W-1:0] scan_data,
  output logic                                 scan_ready_q,
  output logic                                 busy_q,
  output logic                                 irq_q
);

  // ==========================================================================
  // Declarations
  ctrl_t              ctrl_q;
  len_t               len_q;
  eng_state_t         state_q;
  logic [WORD_W-1:0]  data_q;
  logic [WORD_W-1:0]  acc_q;
  logic [WORD_W-1:0]  poly_q;
  logic [WORD_W-1:0]  shift_q;
  logic [CNT_W-1:0]   bit_cnt_q;
  logic [CNT_W-1:0]   zero_cnt_q;
  logic               busy_d;
  logic               busy_prev_q;
  logic               done_event;
  logic               sw_latch;
  logic               scan_take;
  logic               word_start;
  logic [WORD_W-1:0]  word_in;
  logic               bit_in;
  logic               stepping;
  logic [WORD_W-1:0]  acc_next;
  logic               flag_q;
  logic               mask_q;
  logic               status_rd;

  // ==========================================================================
  // Register decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  // Software words only when the scanner is not the selected source
  assign sw_latch  = wr_en & hit(addr, OFS_DATA_LO) & ctrl_q.enable
                     & ~ctrl_q.src_scan;
  assign scan_take = scan_valid & scan_ready_q;
  assign word_start = sw_latch | scan_take;
  assign status_rd = rd_en & hit(addr, OFS_STATUS);

  // Word seen by the shifter: scanner word, or for software words the held high byte with the written low byte
  always_comb
  begin
    if (scan_take)
      word_in = scan_data;
    else
      word_in = {data_q[WORD_W-1:DATA_W], wdata};
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= '0;
      len_q  <= '{poly_len: LEN_RST, data_len: LEN_RST};
    end
    else if (wr_en && hit(addr, OFS_CTRL0))
    begin
      ctrl_q.enable    <= wdata[CTRL0_ENABLE_BIT];
      ctrl_q.augment   <= wdata[CTRL0_AUG_BIT];
      ctrl_q.src_scan  <= wdata[CTRL0_SRC_BIT];
      ctrl_q.order_lsb <= wdata[CTRL0_ORDER_BIT];
    end
    else if (wr_en && hit(addr, OFS_CTRL1))
    begin
      len_q <= wdata;
    end
  end

  // Data and polynomial holding registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_q <= WORD_RST;
      poly_q <= WORD_RST;
    end
    else if (wr_en)
    begin
      if (hit(addr, OFS_DATA_LO))
        data_q[DATA_W-1:0] <= wdata;
      if (hit(addr, OFS_DATA_HI))
        data_q[WORD_W-1:DATA_W] <= wdata;
      if (hit(addr, OFS_POLY_LO))
        poly_q[DATA_W-1:0] <= wdata;
      if (hit(addr, OFS_POLY_HI))
        poly_q[WORD_W-1:DATA_W] <= wdata;
    end
  end

  // ==========================================================================
  // Sequencer: data bits, then optional zero bits
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= CNT_ZERO;
      zero_cnt_q <= CNT_ZERO;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (word_start)
          begin
            state_q    <= ST_DATA;
            bit_cnt_q  <= len_count(len_q.data_len);
            zero_cnt_q <= ctrl_q.augment ? len_count(len_q.poly_len)
                                         : CNT_ZERO;
          end
        end
        ST_DATA:
        begin
          bit_cnt_q <= bit_cnt_q - CNT_ONE;
          if (bit_cnt_q == CNT_ONE)
          begin
            if (zero_cnt_q != CNT_ZERO)
              state_q <= ST_AUG;
            else
              state_q <= ST_IDLE;
          end
        end
        ST_AUG:
        begin
          zero_cnt_q <= zero_cnt_q - CNT_ONE;
          if (zero_cnt_q == CNT_ONE)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Staging shifter; masking drops data bits above the length
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      shift_q <= WORD_RST;
    else if (state_q == ST_IDLE && word_start)
      shift_q <= word_in & len_mask(len_q.data_len);
    else if (state_q == ST_DATA && ctrl_q.order_lsb)
      shift_q <= {1'b0, shift_q[WORD_W-1:1]};
    else if (state_q == ST_DATA)
      shift_q <= {shift_q[WORD_W-2:0], 1'b0};
  end

  // Bit offered to the accumulator this cycle
  always_comb
  begin
    stepping = (state_q == ST_DATA) || (state_q == ST_AUG);
    if (state_q == ST_AUG)
      bit_in = 1'b0;
    else if (ctrl_q.order_lsb)
      bit_in = shift_q[0];
    else
      bit_in = shift_q[len_q.data_len];
  end

  crc_lfsr_step u_step (
    .acc      (acc_q),
    .poly     (poly_q),
    .poly_len (len_q.poly_len),
    .bit_in   (bit_in),
    .acc_next (acc_next)
  );

  // ==========================================================================
  // Accumulator: seed writes win over a step in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      acc_q <= WORD_RST;
    else if (wr_en && hit(addr, OFS_ACC_LO))
      acc_q[DATA_W-1:0] <= wdata;
    else if (wr_en && hit(addr, OFS_ACC_HI))
      acc_q[WORD_W-1:DATA_W] <= wdata;
    else if (stepping)
      acc_q <= acc_next;
  end

  // ==========================================================================
  // Busy and its falling edge
  always_comb
  begin
    unique case (state_q)
      ST_IDLE: busy_d = word_start;
      ST_DATA: busy_d = (bit_cnt_q != CNT_ONE) || (zero_cnt_q != CNT_ZERO);
      ST_AUG:  busy_d = zero_cnt_q != CNT_ONE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q      <= 1'b0;
      busy_prev_q <= 1'b0;
    end
    else
    begin
      busy_q      <= busy_d;
      busy_prev_q <= busy_q;
    end
  end

  assign done_event = busy_prev_q & ~busy_q;

  // Ready only when idle, scanner selected and nothing starting
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      scan_ready_q <= 1'b0;
    else
      scan_ready_q <= ctrl_q.enable & ctrl_q.src_scan & ~busy_d
                      & ~(wr_en & hit(addr, OFS_CTRL0));
  end

  crc_done_irq u_irq (
    .clk        (clk),
    .rstn       (rstn),
    .done_event (done_event),
    .flag_clear (status_rd),
    .mask_we    (wr_en & hit(addr, OFS_MASK)),
    .mask_wdata (wdata[DONE_BIT]),
    .flag_q     (flag_q),
    .mask_q     (mask_q),
    .irq_q      (irq_q)
  );

  // ==========================================================================
  // Read port: data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= BYTE_ZERO;
    else if (!rd_en)
      rdata_q <= BYTE_ZERO;
    else
    begin
      rdata_q <= BYTE_ZERO;
      unique case (addr)
        OFS_CTRL0:
        begin
          rdata_q[CTRL0_ENABLE_BIT] <= ctrl_q.enable;
          rdata_q[CTRL0_BUSY_BIT]   <= busy_q;
          rdata_q[CTRL0_AUG_BIT]    <= ctrl_q.augment;
          rdata_q[CTRL0_SRC_BIT]    <= ctrl_q.src_scan;
          rdata_q[CTRL0_ORDER_BIT]  <= ctrl_q.order_lsb;
        end
        OFS_CTRL1:    rdata_q <= len_q;
        OFS_DATA_LO:  rdata_q <= data_q[DATA_W-1:0];
        OFS_DATA_HI:  rdata_q <= data_q[WORD_W-1:DATA_W];
        OFS_ACC_LO:   rdata_q <= acc_q[DATA_W-1:0];
        OFS_ACC_HI:   rdata_q <= acc_q[WORD_W-1:DATA_W];
        OFS_POLY_LO:  rdata_q <= poly_q[DATA_W-1:0];
        OFS_POLY_HI:  rdata_q <= poly_q[WORD_W-1:DATA_W];
        OFS_STATUS:   rdata_q[DONE_BIT] <= flag_q;
        OFS_MASK:     rdata_q[DONE_BIT] <= mask_q;
        OFS_SHIFT_LO: rdata_q <= shift_q[DATA_W-1:0];
        OFS_SHIFT_HI: rdata_q <= shift_q[WORD_W-1:DATA_W];
        default:      rdata_q <= BYTE_ZERO;
      endcase
    end
  end

endmodule : crc_calc_engine

`default_nettype wire

/* File: sim/crc_scan_model.sv */
// Behavioural memory scanner that offers words to the check engine
`timescale 1ns/1ps
`default_nettype none

module crc_scan_model
  import crc_calc_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            go,
  input  wire logic [3:0]                      lag,
  input  wire logic [crc_calc_pkg::WORD_W-1:0] word,
  input  wire logic                            scan_ready_q,
  output logic                                 scan_valid,
  output logic      [crc_calc_pkg::WORD_W-1:0] scan_data,
  output logic                                 taken
);
  logic       pend_q;
  logic [3:0] wait_q;

  // ==========================================================================
  // Offer handshake
  // Word held until taken; then the bus shows junk so no stale copy passes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_q     <= 1'b0;
      wait_q     <= 4'h0;
      scan_valid <= 1'b0;
      scan_data  <= 16'h0000;
      taken      <= 1'b0;
    end
    else
    begin
      taken <= 1'b0;
      if (go)
      begin
        pend_q <= 1'b1;
        wait_q <= lag;
      end
      else if (pend_q && !scan_valid && wait_q == 4'h0)
      begin
        scan_valid <= 1'b1;
        scan_data  <= word;
      end
      else if (pend_q && !scan_valid)
        wait_q <= wait_q - 4'h1;
      else if (scan_valid && scan_ready_q)
      begin
        scan_valid <= 1'b0;
        pend_q     <= 1'b0;
        taken      <= 1'b1;
        scan_data  <= ~scan_data;
      end
    end
  end
endmodule : crc_scan_model
`default_nettype wire

/* File: sim/crc_calc_engine_properties.sv */
// Port-level assertions of the check engine
`timescale 1ns/1ps
`default_nettype none

module crc_calc_engine_properties
  import crc_calc_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            rstn,
  input wire logic [crc_calc_pkg::ADDR_W-1:0] addr,
  input wire logic                            wr_en,
  input wire logic                            rd_en,
  input wire logic [crc_calc_pkg::DATA_W-1:0] rdata_q,
  input wire logic                            scan_valid,
  input wire logic                            scan_ready_q,
  input wire logic                            busy_q,
  input wire logic                            irq_q
);
  logic lo_wr;
  logic mask_wr;
  logic stat_rd;
  logic take;

  // ==========================================================================
  // Decoded bus events, so that past values stay plain signals
  assign lo_wr   = wr_en && (addr == OFS_DATA_LO);
  assign mask_wr = wr_en && (addr == OFS_MASK);
  assign stat_rd = rd_en && (addr == OFS_STATUS);
  assign take    = scan_valid && scan_ready_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Word start steps
  sequence s_take;
    take;
  endsequence
  sequence s_lo_refused;
    lo_wr && scan_ready_q && !scan_valid && !busy_q;
  endsequence

  // ==========================================================================
  // Start, length, scanner handshake and read port
  a_start_cause: assert property (
    $rose(busy_q) |-> $past(lo_wr) || $past(take))
    else $error("busy rose without a word");
  a_take_busy: assert property (s_take |=> busy_q && !scan_ready_q)
    else $error("scanner take did not start a word");
  a_lo_refused: assert property (s_lo_refused |=> !busy_q)
    else $error("data write started in scanner mode");
  a_busy_bound: assert property ($rose(busy_q) |-> ##[1:32] !busy_q)
    else $error("word longer than data plus zeros");
  a_ready_busy: assert property (busy_q |-> !scan_ready_q)
    else $error("scanner ready while busy");
  a_read_one: assert property (!$past(rd_en) |-> rdata_q == BYTE_ZERO)
    else $error("read data outside its cycle");

  // ==========================================================================
  // Completion interrupt
  a_irq_rise: assert property ($rose(irq_q) |->
    $past(mask_wr, 2) || ($past(busy_q, 3) && !$past(busy_q, 2)))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq_q) |->
    $past(stat_rd, 2) || $past(mask_wr, 2))
    else $error("interrupt fell without software");
endmodule : crc_calc_engine_properties

bind crc_calc_engine crc_calc_engine_properties chk_u (.clk(clk), .rstn(rstn), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .scan_valid(scan_valid),
  .scan_ready_q(scan_ready_q), .busy_q(busy_q), .irq_q(irq_q));
`default_nettype wire

/* File: sim/crc_calc_engine_test.sv */
// Self-checking bench of the check engine
`timescale 1ns/1ps
`default_nettype none

module crc_calc_engine_test;
  import crc_calc_pkg::*;

  localparam logic [15:0] POLY = 16'h1021;
  // Cases: control0, control1, seed, word
  localparam logic [47:0] CASES [4] = '{48'h80ff_ffff_1234, 48'h82f7_0000_ab5c,
                                       48'h90f3_1d0f_fff9, 48'h9270_00ff_0001};

  logic              clk;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rdata_q;
  logic              scan_valid;
  logic [WORD_W-1:0] scan_data;
  logic              scan_ready_q;
  logic              busy_q;
  logic              irq_q;
  logic              go;
  logic [3:0]        lag;
  logic [WORD_W-1:0] word;
  logic              taken;
  int                err_total;
  int                n_checks;

  crc_calc_engine dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .scan_valid(scan_valid), .scan_data(scan_data),
    .scan_ready_q(scan_ready_q), .busy_q(busy_q), .irq_q(irq_q));
  crc_scan_model scan_u (.clk(clk), .rstn(rstn), .go(go), .lag(lag), .word(word),
    .scan_ready_q(scan_ready_q), .scan_valid(scan_valid), .scan_data(scan_data),
    .taken(taken));

  // ==========================================================================
  // Clock
  always #20 clk = ~clk;

  // ==========================================================================
  // Bus, compare and model tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string m);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({8'h00, rdata_q}, {8'h00, e}, m);
  endtask : rdc

  // Counts busy cycles from just after the start edge
  task automatic busy_len(input int exp);
    int n;
    n = 0;
    #1;
    while (busy_q === 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(exp), "busy cycles");
  endtask : busy_len

  function automatic logic [15:0] step(input logic [15:0] a, input logic [3:0] pl,
                                       input logic b);
    logic fb;
    fb = a[pl] ^ b;
    a  = (a << 1) ^ (fb ? POLY : 16'h0000);
    return a & (16'hffff >> (4'hf - pl));
  endfunction : step

  function automatic logic [15:0] crc_ref(input logic [15:0] a, input logic [7:0] c0,
                                          input logic [7:0] c1, input logic [15:0] w);
    for (int i = 0; i <= int'(c1[3:0]); i++)
      a = step(a, c1[7:4], c0[1] ? w[i] : w[int'(c1[3:0]) - i]);
    if (c0[4])
      for (int i = 0; i <= int'(c1[7:4]); i++)
        a = step(a, c1[7:4], 1'b0);
    return a;
  endfunction : crc_ref

  task automatic sw_word(input logic [15:0] w);
    wr(OFS_DATA_HI, w[15:8]);
    wr(OFS_DATA_LO, w[7:0]);
  endtask : sw_word

  task automatic scan_word(input logic [15:0] w, input logic [3:0] l);
    int n;
    n = 0;
    @(posedge clk);
    word <= w;
    lag  <= l;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (taken !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    busy_len(16);
  endtask : scan_word

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rdc(OFS_CTRL1, 8'hff, "length reset");
    rdc(OFS_CTRL0, 8'h00, "control reset");
    rdc(OFS_ACC_LO, 8'h00, "acc reset");
    chk({15'h0, irq_q}, 16'h0000, "irq reset");
    wr(4'hc, 8'h5a);
    rdc(4'hc, 8'h00, "unmapped");
    wr(OFS_DATA_LO, 8'h11);
    #1 chk({15'h0, busy_q}, 16'h0000, "disabled start");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_words;
    logic [47:0] c;
    logic [15:0] e;
    wr(OFS_POLY_LO, POLY[7:0]);
    wr(OFS_POLY_HI, POLY[15:8]);
    for (int k = 0; k < 4; k++)
    begin
      c = CASES[k];
      e = crc_ref(c[31:16], c[47:40], c[39:32], c[15:0]);
      wr(OFS_CTRL0, c[47:40]);
      wr(OFS_CTRL1, c[39:32]);
      wr(OFS_ACC_LO, c[23:16]);
      wr(OFS_ACC_HI, c[31:24]);
      sw_word(c[15:0]);
      busy_len(int'(c[35:32]) + 1 + (c[44] ? int'(c[39:36]) + 1 : 0));
      rdc(OFS_ACC_LO, e[7:0], "acc low");
      rdc(OFS_ACC_HI, e[15:8], "acc high");
      rdc(OFS_STATUS, 8'h01, "flag unmasked off");
    end
    $display("t_words done");
  endtask : t_words

  task automatic t_irq;
    wr(OFS_CTRL0, 8'h80);
    wr(OFS_CTRL1, 8'hff);
    wr(OFS_MASK, 8'h01);
    sw_word(16'h5555);
    busy_len(16);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq_q}, 16'h0001, "irq raised");
    repeat (6) @(posedge clk);
    #1 chk({15'h0, irq_q}, 16'h0001, "irq held");
    rdc(OFS_STATUS, 8'h01, "flag read");
    @(posedge clk);
    #1 chk({15'h0, irq_q}, 16'h0000, "irq cleared");
    wr(OFS_MASK, 8'h00);
    sw_word(16'h00aa);
    busy_len(16);
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq_q}, 16'h0000, "irq masked");
    wr(OFS_MASK, 8'h01);
    @(posedge clk);
    #1 chk({15'h0, irq_q}, 16'h0001, "irq unmasked");
    rdc(OFS_STATUS, 8'h01, "flag masked");
    $display("t_irq done");
  endtask : t_irq

  // Software finishing by itself: appended zeros, then the check value fed back
  task automatic t_feed;
    logic [15:0] e;
    e = crc_ref(16'hffff, 8'h90, 8'hff, 16'hc3a5);
    wr(OFS_CTRL0, 8'h80);
    wr(OFS_ACC_LO, 8'hff);
    wr(OFS_ACC_HI, 8'hff);
    sw_word(16'hc3a5);
    rdc(OFS_CTRL0, 8'ha0, "busy bit");
    busy_len(14);
    sw_word(16'h0000);
    busy_len(16);
    rdc(OFS_ACC_LO, e[7:0], "zeros fed low");
    rdc(OFS_ACC_HI, e[15:8], "zeros fed high");
    e = crc_ref(16'hffff, 8'h80, 8'hff, 16'hc3a5);
    wr(OFS_ACC_LO, 8'hff);
    wr(OFS_ACC_HI, 8'hff);
    sw_word(16'hc3a5);
    busy_len(16);
    sw_word(e);
    busy_len(16);
    rdc(OFS_ACC_LO, 8'h00, "check fed low");
    rdc(OFS_ACC_HI, 8'h00, "check fed high");
    $display("t_feed done");
  endtask : t_feed

  task automatic t_scan;
    logic [15:0] e;
    e = crc_ref(crc_ref(16'h0000, 8'h84, 8'hff, 16'hbeef), 8'h84, 8'hff, 16'h0f0f);
    wr(OFS_ACC_LO, 8'h00);
    wr(OFS_ACC_HI, 8'h00);
    wr(OFS_CTRL0, 8'h84);
    wr(OFS_DATA_LO, 8'h33);
    #1 chk({15'h0, busy_q}, 16'h0000, "data write in scan mode");
    chk({15'h0, scan_ready_q}, 16'h0001, "scanner ready");
    scan_word(16'hbeef, 4'h0);
    scan_word(16'h0f0f, 4'h3);
    rdc(OFS_ACC_LO, e[7:0], "scan acc low");
    rdc(OFS_ACC_HI, e[15:8], "scan acc high");
    $display("t_scan done");
  endtask : t_scan

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    go = 1'b0;
    lag = 4'h0;
    word = 16'h0000;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_words;
    t_irq;
    t_feed;
    t_scan;
    wrap_up;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up;
  end
endmodule : crc_calc_engine_test
`default_nettype wire
